// File: hdl/pbf_pkg.sv
package pbf_pkg;
   // register byte addresses (word aligned)
   localparam logic [3:0] ADDR_FUNC_SEL = 4'h0;
   localparam logic [3:0] ADDR_UPPER    = 4'h4;
   localparam logic [3:0] ADDR_LOWER    = 4'h8;
   localparam logic [3:0] ADDR_DIR      = 4'hC;

   // writable masks of each register
   localparam logic [15:0] FUNC_WMASK  = 16'h7777;
   localparam logic [15:0] UPPER_WMASK = 16'h0007;
   localparam logic [15:0] LOWER_WMASK = 16'h003C;
   localparam logic [15:0] DIR_WMASK   = 16'h007F;

   // reset values; boot-mode bits 14,12,10,8
   localparam logic [15:0] FUNC_RESET      = 16'h0000;
   localparam logic [15:0] FUNC_EXTBOOT    = 16'h5500;
   localparam logic [15:0] DATA_RESET      = 16'h0000;

   // line 3 and line 2 selector field positions and codes
   localparam int         L3_FUNC_LSB  = 12;
   localparam int         L2_FUNC_LSB  = 8;
   localparam logic [2:0] FN_GPIO      = 3'h0;
   localparam logic [2:0] FN_EXT_INT1  = 3'h1;
   localparam logic [2:0] FN_OUT_DIS1  = 3'h2;
   localparam logic [2:0] FN_TIMER_CAP = 3'h3;
   localparam logic [2:0] FN_ADDR17    = 3'h5;

   // wishbone request bundle
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  adr;
      logic [1:0]  sel;
      logic [15:0] dat;
   } pbf_req_s;
endpackage : pbf_pkg

// File: hdl/pbf_port_b.sv
`timescale 1ns/1ns
// Summary of operation
// - function register bits 15,11,7,3 read zero; writes to them ignored
// - line 3 selector codes: io, external interrupt 1, out-disable1, timer capture, addr17
// - bits 14,12,10,8 set to one at the first edge after reset release in rom-disabled external mode
// - upper data bits 2..0 for lines 18..16, others read zero
// - lower data bits 5..2 for lines 5..2, others read zero
module pbf_port_b (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // boot mode strap: rom disabled, external extension
   input  wire logic             ext_rom_off_mode,
   // wishbone slave
   input  wire pbf_pkg::pbf_req_s wb_req,
   output logic [15:0]           wb_dat_o,
   output logic                  wb_ack_o,
   // line 3 peripheral paths
   input  wire logic             addr17_in,
   output logic                  ext_int1_o,
   output logic                  out_disable1_o,
   output logic                  timer_cap_o,
   // pins for lines 2..5 and 16..18
   input  wire logic [6:0]       pin_i,
   output logic [6:0]            pin_o,
   output logic [6:0]            pin_oe_n
);
   // register state and next values
   logic [15:0] func_reg,      func_next;
   logic [15:0] upper_reg,     upper_next;
   logic [15:0] lower_reg,     lower_next;
   logic [15:0] dir_reg,       dir_next;
   logic [15:0] rdat_reg,      rdat_next;
   logic        ack_reg,       ack_next;
   logic        boot_seen_reg, boot_seen_next;
   // bus decode
   logic        req;
   logic        wr;
   logic        wr_func;
   logic        wr_upper;
   logic        wr_lower;
   logic        wr_dir;
   // line decode
   logic [2:0]  l2_func;
   logic [2:0]  l3_func;
   logic [6:0]  data_vec;
   logic [6:0]  gpio_sel;

   // merge write data under byte lanes and writable mask
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                         input logic [1:0] sel, input logic [15:0] wmask);
      logic [15:0] lane;
      lane  = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
      merge = (old & ~lane) | (wd & lane);
   endfunction : merge

   // compare a three-bit selector against one function code
   function automatic logic is_code(input logic [2:0] code, input logic [2:0] want);
      is_code = (code == want);
   endfunction : is_code

   // true when a selector picks general io
   function automatic logic is_gpio(input logic [2:0] code);
      is_gpio = is_code(code, pbf_pkg::FN_GPIO);
   endfunction : is_gpio

   // a request stands on the bus
   assign req = wb_req.cyc && wb_req.stb;

   // writes land at the edge where the master samples ack high
   assign wr       = req && wb_req.we && ack_reg;
   assign wr_func  = wr && (wb_req.adr == pbf_pkg::ADDR_FUNC_SEL);
   assign wr_upper = wr && (wb_req.adr == pbf_pkg::ADDR_UPPER);
   assign wr_lower = wr && (wb_req.adr == pbf_pkg::ADDR_LOWER);
   assign wr_dir   = wr && (wb_req.adr == pbf_pkg::ADDR_DIR);

   // ack after one wait state, held for exactly one cycle
   always_comb begin
      ack_next = req && !ack_reg;
   end

   // ack register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= ack_next;
      end
   end

   // boot flag: low only up to the first edge after reset release
   always_comb begin
      boot_seen_next = 1'b1;
   end

   // boot flag register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_seen_reg <= 1'b0;
      end else begin
         boot_seen_reg <= boot_seen_next;
      end
   end

   // function select next value
   always_comb begin
      func_next = func_reg;
      // boot preset: strap taken after release, reset holds constants only
      if (!boot_seen_reg && ext_rom_off_mode) begin
         func_next = func_reg | pbf_pkg::FUNC_EXTBOOT;
      end
      if (wr_func) begin
         func_next = merge(func_reg, wb_req.dat, wb_req.sel, pbf_pkg::FUNC_WMASK);
      end
   end

   // function select register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         func_reg <= pbf_pkg::FUNC_RESET;
      end else begin
         func_reg <= func_next;
      end
   end

   // upper data next value, lines 18..16 only
   always_comb begin
      upper_next = upper_reg;
      if (wr_upper) begin
         upper_next = merge(upper_reg, wb_req.dat, wb_req.sel, pbf_pkg::UPPER_WMASK);
      end
   end

   // upper data register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         upper_reg <= pbf_pkg::DATA_RESET;
      end else begin
         upper_reg <= upper_next;
      end
   end

   // lower data next value, lines 5..2 only
   always_comb begin
      lower_next = lower_reg;
      if (wr_lower) begin
         lower_next = merge(lower_reg, wb_req.dat, wb_req.sel, pbf_pkg::LOWER_WMASK);
      end
   end

   // lower data register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lower_reg <= pbf_pkg::DATA_RESET;
      end else begin
         lower_reg <= lower_next;
      end
   end

   // direction next value: one bit per line, 1 = output
   always_comb begin
      dir_next = dir_reg;
      if (wr_dir) begin
         dir_next = merge(dir_reg, wb_req.dat, wb_req.sel, pbf_pkg::DIR_WMASK);
      end
   end

   // direction register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dir_reg <= pbf_pkg::DATA_RESET;
      end else begin
         dir_reg <= dir_next;
      end
   end

   // read data: captured at the take edge, shown with ack
   always_comb begin
      rdat_next = rdat_reg;
      if (ack_next) begin
         case (wb_req.adr)
            pbf_pkg::ADDR_FUNC_SEL: rdat_next = func_reg & pbf_pkg::FUNC_WMASK;
            pbf_pkg::ADDR_UPPER:    rdat_next = upper_reg & pbf_pkg::UPPER_WMASK;
            // bits 15..6 and 1..0 read zero
            pbf_pkg::ADDR_LOWER:    rdat_next = lower_reg & pbf_pkg::LOWER_WMASK;
            pbf_pkg::ADDR_DIR:      rdat_next = dir_reg & pbf_pkg::DIR_WMASK;
            // unmapped offsets read zero
            default:                rdat_next = 16'h0000;
         endcase
      end
   end

   // read data register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdat_reg <= 16'h0000;
      end else begin
         rdat_reg <= rdat_next;
      end
   end

   // bus outputs straight from flip-flops
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;

   // line 3 routing; the pin level reaches only the selected unit
   assign l3_func        = func_reg[pbf_pkg::L3_FUNC_LSB +: 3];
   assign ext_int1_o     = is_code(l3_func, pbf_pkg::FN_EXT_INT1)  && pin_i[1];
   assign out_disable1_o = is_code(l3_func, pbf_pkg::FN_OUT_DIS1)  && pin_i[1];
   assign timer_cap_o    = is_code(l3_func, pbf_pkg::FN_TIMER_CAP) && pin_i[1];

   // lines in order 2,3,4,5,16,17,18; line 4 selector lives outside this block
   assign l2_func  = func_reg[pbf_pkg::L2_FUNC_LSB +: 3];
   assign data_vec = {upper_reg[2:0], lower_reg[5:2]};
   assign gpio_sel = {3'h7, 1'b1, 1'b1, is_gpio(l3_func), is_gpio(l2_func)};

   // pin drive for general io outputs; line 3 address output
   always_comb begin
      pin_o    = data_vec & gpio_sel;
      pin_oe_n = ~(dir_reg[6:0] & gpio_sel);
      // address bit 17 drives line 3 whatever the direction bit
      if (is_code(l3_func, pbf_pkg::FN_ADDR17)) begin
         pin_o[1]    = addr17_in;
         pin_oe_n[1] = 1'b0;
      end
   end
endmodule : pbf_port_b

// File: testbench/pbf_port_b_chk.sv
`timescale 1ns/1ns
module pbf_port_b_chk (
   // clock and reset
   input logic              clk,
   input logic              rst_n,
   // bus and line 3 paths
   input pbf_pkg::pbf_req_s wb_req,
   input logic [15:0]       wb_dat_o,
   input logic              wb_ack_o,
   input logic              ext_int1_o,
   input logic              out_disable1_o,
   input logic              timer_cap_o,
   input logic [6:0]        pin_i
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // read answer of one address shows no masked bit
   property rd_zero(a, m);
      wb_ack_o && !$past(wb_req.we) && $past(wb_req.adr) == a |-> (wb_dat_o & m) == 16'h0000;
   endproperty
   chk_func_resv: assert property (rd_zero(4'h0, 16'h8888))
      else $error("function reserved bits set");
   chk_upper_resv: assert property (rd_zero(4'h4, 16'hFFF8))
      else $error("upper reserved bits set");
   chk_lower_resv: assert property (rd_zero(4'h8, 16'hFFC3))
      else $error("lower reserved bits set");
   chk_line3_route: assert property (ext_int1_o || out_disable1_o || timer_cap_o
      |-> pin_i[1] && $onehot0({ext_int1_o, out_disable1_o, timer_cap_o}))
      else $error("line 3 routing wrong");
   // one wait state, one-cycle ack
   chk_ack_wait: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   cover property (ext_int1_o);
   cover property (wb_ack_o && $past(wb_req.we));
   cover property (wb_ack_o && !$past(wb_req.we) && $past(wb_req.adr) == 4'h8);
endmodule : pbf_port_b_chk
bind pbf_port_b pbf_port_b_chk u_chk (.clk, .rst_n, .wb_req, .wb_dat_o, .wb_ack_o, .ext_int1_o, .out_disable1_o,
   .timer_cap_o, .pin_i);

// File: testbench/pbf_port_b_tb.sv
`timescale 1ns/1ns
module pbf_port_b_tb;
   logic              clk = 1'b0, rst_n = 1'b0, strap = 1'b1, addr_in = 1'b1, ack, irq, od, tc;
   logic [6:0]        pins = 7'h7F;
   pbf_pkg::pbf_req_s rq = '0;
   logic [15:0]       dat, rv;
   logic [6:0]        po, oen;
   logic [2:0]        codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
   int                n_fail = 0, num_checks = 0, cyc = 0;
   always #2 clk = ~clk;
   pbf_port_b u_dut (.clk(clk), .rst_n(rst_n), .ext_rom_off_mode(strap), .wb_req(rq), .wb_dat_o(dat),
      .wb_ack_o(ack), .addr17_in(addr_in), .ext_int1_o(irq), .out_disable1_o(od), .timer_cap_o(tc),
      .pin_i(pins), .pin_o(po), .pin_oe_n(oen));
   // compare and count
   task cmp(string nm, logic [15:0] e, logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask : cmp
   // classic wishbone cycle, waits for ack
   task bus(logic w, logic [3:0] a, logic [15:0] d);
      rq <= '{1'b1, 1'b1, w, a, 2'h3, d};
      do @(posedge clk); while (ack !== 1'b1);
      rv = dat;
      rq <= '0;
      @(posedge clk);
   endtask : bus
   task rd(logic [3:0] a, logic [15:0] e);
      bus(1'b0, a, 16'h0000);
      cmp("read", e, rv);
   endtask : rd
   // reset with a boot strap level
   task rst(logic s);
      strap <= s;
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask : rst
   task conclude;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude
   // run-time ceiling
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 1000) begin
         n_fail++;
         conclude();
      end
   end
   // scenarios
   initial begin
      rst(1'b1);
      rd(4'h0, 16'h5500);
      rd(4'h4, 16'h0000);
      rd(4'h8, 16'h0000);
      bus(1'b1, 4'h0, 16'h5555);
      rd(4'h0, 16'h5555);
      bus(1'b1, 4'h4, 16'h0007);
      rd(4'h4, 16'h0007);
      bus(1'b1, 4'h8, 16'h003C);
      rd(4'h8, 16'h003C);
      bus(1'b1, 4'h8, 16'h0000);
      bus(1'b1, 4'hE, 16'hFFFF);
      rd(4'hE, 16'h0000);
      foreach (codes[i]) begin
         bus(1'b1, 4'h0, {1'b0, codes[i], 12'h000});
         cmp("route", {13'h0, codes[i] == 1, codes[i] == 2, codes[i] == 3}, {13'h0, irq, od, tc});
         cmp("addr out", {14'h0, codes[i] == 5, codes[i] != 5}, {14'h0, po[1], oen[1]});
         pins    <= 7'h7D;
         addr_in <= 1'b0;
         @(posedge clk);
         cmp("route low", 16'h0000, {13'h0, irq, od, tc});
         cmp("addr out low", {15'h0, codes[i] != 5}, {14'h0, po[1], oen[1]});
         pins    <= 7'h7F;
         addr_in <= 1'b1;
      end
      bus(1'b1, 4'h0, 16'h0000);
      bus(1'b1, 4'hC, 16'h007F);
      rd(4'hC, 16'h007F);
      bus(1'b1, 4'h8, 16'h002C);
      bus(1'b1, 4'h4, 16'h0005);
      cmp("pins", 16'h005B, {2'h0, oen, po});
      bus(1'b1, 4'h0, 16'h1000);
      cmp("pins func", 16'h0159, {2'h0, oen, po});
      rst(1'b0);
      rd(4'h0, 16'h0000);
      rd(4'h4, 16'h0000);
      rd(4'h8, 16'h0000);
      cmp("pins reset", 16'h3F80, {2'h0, oen, po});
      conclude();
   end
endmodule : pbf_port_b_tb
